/* File: ccs_pkg.sv */
// Shared constants, types and register layout of the charge cycle supervisor.
package ccs_pkg;
	// ----------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_HIZ = 4'h0;
	localparam logic [3:0] REG_CHG_CFG = 4'h1;
	localparam logic [3:0] REG_CUR = 4'h2;
	localparam logic [3:0] REG_VREG = 4'h4;
	localparam logic [3:0] REG_TERM = 4'h5;
	localparam logic [3:0] REG_COMP = 4'h6;
	localparam logic [3:0] REG_MISC = 4'h7;
	localparam logic [3:0] REG_STAT = 4'h8;
	localparam logic [3:0] REG_FAULT = 4'h9;
	localparam logic [3:0] REG_MODE = 4'ha;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int HIZ_BIT = 7;
	localparam int CFG_LSB = 4;
	localparam int TERM_EN_BIT = 7;
	localparam int EARLY_BIT = 6;
	localparam int TMR_EN_BIT = 3;
	localparam int DUR_LSB = 1;
	localparam int RCOMP_LSB = 5;
	localparam int CLAMP_LSB = 2;
	localparam int HALF_EN_BIT = 6;
	localparam int STAT_LSB = 4;
	localparam int CFAULT_LSB = 4;
	// ----------------------------------------------------------------
	// Reset values and codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CFG_RST = 2'h1;
	localparam logic [1:0] CFG_CHARGE = 2'h1;
	localparam logic [1:0] DUR_RST = 2'h1;
	localparam logic [5:0] VREG_RST = 6'h17;
	localparam logic [1:0] ST_IDLE = 2'h0;
	localparam logic [1:0] ST_FAST = 2'h2;
	localparam logic [1:0] ST_DONE = 2'h3;
	localparam logic [1:0] CF_TIMER = 2'h3;
	// ----------------------------------------------------------------
	// Scaling and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] VREG_BASE_MV = 16'h0dac;
	localparam logic [15:0] VREG_LSB_MV = 16'h0010;
	localparam logic [7:0] RCOMP_LSB_MOHM = 8'h0a;
	localparam logic [15:0] CLAMP_LSB_MV = 16'h0010;
	localparam logic [11:0] EARLY_DONE_MA = 12'h320;
	localparam int CLK_HZ = 40_000_000;
	localparam int HOUR_S = 3600;
	localparam int MIN_S = 60;
	localparam int DEF_HRS = 5;
	localparam int LOWBAT_HRS = 1;
	localparam int USB_MIN = 45;
	localparam int ALERT_US = 256;
	localparam int ALERT_CYC = (ALERT_US * (CLK_HZ / 1_000_000));
	localparam int TIMER_W = 17;
	typedef enum logic [4:0] {
		CCS_IDLE = 5'b00001,
		CCS_CHARGE = 5'b00010,
		CCS_SUSPEND = 5'b00100,
		CCS_DONE = 5'b01000,
		CCS_TFAULT = 5'b10000
	} ccs_state_t;
	typedef struct packed {
		logic vbat_above_recharge;
		logic vbat_below_low;
		logic ichg_below_term;
		logic iin_reg;
		logic vin_reg;
		logic therm_reg;
	} ccs_batt_t;
	typedef struct packed {
		logic above_undervoltage_lockout;
		logic above_bat;
		logic below_ovp;
		logic not_poor;
		logic usb100;
	} ccs_src_t;
endpackage : ccs_pkg

/* File: ccs_timer.sv */
// Seconds counter with half-rate option used for the charge timers.
`timescale 1ns/1ps
`default_nettype none
module ccs_timer #(
	parameter int W = 17
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic run,
	input wire logic tick,
	input wire logic half,
	input wire logic [W-1:0] limit,
	output logic expired
);
	logic [W-1:0] count;
	logic phase;
	logic step;
	assign step = run && tick && (!half || phase);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 1'b0;
		end else if (clear) begin
			phase <= 1'b0;
		end else if (run && tick && half) begin
			phase <= !phase;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			expired <= 1'b0;
		end else if (clear) begin
			count <= '0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (step) begin
				if (count + 1'b1 >= limit) begin
					count <= '0;
					expired <= 1'b1;
				end else begin
					count <= count + 1'b1;
				end
			end
		end
	end
endmodule : ccs_timer
`default_nettype wire

/* File: ccs_supervisor.sv */
// Charge cycle supervisor: regulation target, thermistor checks, timers, alert.
// What this block does
// - Raise regulation by min(current*resistance, clamp).
// - Watch both thermistor inputs independently.
// - Start charging only inside start window.
// - Suspend outside run window; resume in start.
// - Report thermistor states in fault field, alert.
// - Terminate on voltage high, current low.
// - Termination sets status done and alerts.
// - No termination during any regulation loop.
// - No termination while termination enable zero.
// - Early done indication below 800 mA.
// - Default mode: 5 h timer sets high impedance.
// - Host mode: programmed timer clears high impedance.
// - Low battery limits safety timer to 1 h.
// - Timer expiry loads timer fault, alerts.
// - Safety timer stops while disabled.
// - Four events restart the safety timer.
// - Half rate during regulation or reduced current.
// - USB 100 mA source limited to 45 minutes in default mode.
// - Power good low when four conditions hold.
// - Each alert is one 256 us low pulse.
// - Faults latched until read; fault alerts held off.
`timescale 1ns/1ps
`default_nettype none
module ccs_supervisor import ccs_pkg::*; #(
	parameter int TICK_CYCLES = CLK_HZ,
	parameter int ALERT_CYCLES = ALERT_CYC,
	parameter int SAFE_HRS0 = 5,
	parameter int SAFE_HRS1 = 8,
	parameter int SAFE_HRS2 = 12,
	parameter int SAFE_HRS3 = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic chg_enable_n,
	input wire ccs_batt_t batt,
	input wire ccs_src_t src,
	input wire logic [11:0] ichg_ma,
	input wire logic [1:0] ts_cold,
	input wire logic [1:0] ts_hot_start,
	input wire logic [1:0] ts_hot_cut,
	output logic [15:0] vreg_mv,
	output logic charge_on,
	output logic battery_switch_on,
	output logic buck_enable,
	output logic charge_done_ind,
	output logic power_good_pin_n,
	output logic alert_n
);
	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic input_high_impedance_bit, reduced_current_bit, host_mode;
	logic term_en, early_done, timer_en, half_en;
	logic [1:0] chg_cfg, timer_dur, chg_stat, chg_fault;
	logic [5:0] vreg_code;
	logic [2:0] rcomp, clamp, ts_fault;
	logic [7:0] fault_reg;
	logic fault_pending;
	logic [3:0] idx;
	logic mapped, wr_done, rd_fault;
	assign idx = paddr[5:2];
	assign mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) && (idx <= REG_MODE)
		&& (idx != 4'h3);
	assign wr_done = psel && penable && pready && pwrite && mapped;
	assign rd_fault = psel && penable && pready && !pwrite && mapped && (idx == REG_FAULT);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= '0;
			if (psel && !penable && !pwrite && mapped) begin
				unique case (idx)
					REG_HIZ: prdata[HIZ_BIT] <= input_high_impedance_bit;
					REG_CHG_CFG: prdata[CFG_LSB+:2] <= chg_cfg;
					REG_CUR: prdata[0] <= reduced_current_bit;
					REG_VREG: prdata[7:2] <= vreg_code;
					REG_TERM: prdata[7:0] <= {term_en, early_done, 2'h0, timer_en, timer_dur,
						1'b0};
					REG_COMP: prdata[7:2] <= {rcomp, clamp};
					REG_MISC: prdata[HALF_EN_BIT] <= half_en;
					REG_STAT: prdata[7:0] <= {2'h0, chg_stat, 2'h0, batt.therm_reg,
						!power_good_pin_n};
					REG_FAULT: prdata[7:0] <= fault_reg;
					default: prdata[0] <= host_mode;
				endcase
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_cfg <= CFG_RST;
			reduced_current_bit <= 1'b0;
			vreg_code <= VREG_RST;
			{term_en, early_done, timer_en, timer_dur} <= {1'b1, 1'b0, 1'b1, DUR_RST};
			{rcomp, clamp} <= 6'h00;
			half_en <= 1'b1;
			host_mode <= 1'b0;
		end else if (wr_done) begin
			unique case (idx)
				REG_CHG_CFG: chg_cfg <= pwdata[CFG_LSB+:2];
				REG_CUR: reduced_current_bit <= pwdata[0];
				REG_VREG: vreg_code <= pwdata[7:2];
				REG_TERM: begin
					term_en <= pwdata[TERM_EN_BIT];
					early_done <= pwdata[EARLY_BIT];
					timer_en <= pwdata[TMR_EN_BIT];
					timer_dur <= pwdata[DUR_LSB+:2];
				end
				REG_COMP: {rcomp, clamp} <= pwdata[7:2];
				REG_MISC: half_en <= pwdata[HALF_EN_BIT];
				REG_MODE: host_mode <= pwdata[0];
				default: ;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Regulation target
	// ----------------------------------------------------------------
	logic [19:0] comp_prod;
	logic [15:0] comp_mv, clamp_mv, base_mv;
	assign comp_prod = 20'(ichg_ma) * (20'(rcomp) * 20'(RCOMP_LSB_MOHM));
	assign comp_mv = 16'(comp_prod / 20'd1000);
	assign clamp_mv = 16'(clamp * CLAMP_LSB_MV);
	assign base_mv = 16'(VREG_BASE_MV + vreg_code * VREG_LSB_MV);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vreg_mv <= VREG_BASE_MV;
		end else begin
			vreg_mv <= 16'(base_mv + ((comp_mv < clamp_mv) ? comp_mv : clamp_mv));
		end
	end
	// ----------------------------------------------------------------
	// Thermistor windows
	// ----------------------------------------------------------------
	logic [1:0] in_start, in_run;
	logic ts_start_ok, ts_run_ok;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ts
			assign in_start[g] = !ts_cold[g] && !ts_hot_start[g];
			assign in_run[g] = !ts_cold[g] && !ts_hot_cut[g];
		end
	endgenerate
	assign ts_start_ok = &in_start;
	assign ts_run_ok = &in_run;
	// ----------------------------------------------------------------
	// Charge sequencing
	// ----------------------------------------------------------------
	ccs_state_t state;
	logic pg_now, chg_req, any_reg, term_ok, new_cycle, safe_exp, usb_exp;
	logic ce_prev, ce_toggled, restart;
	logic [TIMER_W-1:0] safe_limit;
	assign pg_now = src.above_undervoltage_lockout && src.above_bat && src.below_ovp && src.not_poor;
	// Host ends charging by pin or field.
	assign chg_req = !chg_enable_n && (chg_cfg == CFG_CHARGE) && pg_now &&
		!input_high_impedance_bit;
	assign any_reg = batt.iin_reg || batt.vin_reg || batt.therm_reg;
	// Termination blocked by regulation loops; and by the enable bit.
	assign term_ok = batt.vbat_above_recharge && batt.ichg_below_term && !any_reg && term_en;
	// Cycle starts only inside start window.
	assign new_cycle = chg_req && ts_start_ok && (state == CCS_IDLE ||
		(state == CCS_DONE && !batt.vbat_above_recharge));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CCS_IDLE;
		end else if (!chg_req) begin
			state <= CCS_IDLE;
		end else begin
			unique case (state)
				CCS_IDLE, CCS_DONE: if (new_cycle) state <= CCS_CHARGE;
				CCS_CHARGE: begin
					if (safe_exp || usb_exp) begin
						state <= CCS_TFAULT;
					end else if (!ts_run_ok) begin
						state <= CCS_SUSPEND;
					end else if (term_ok) begin
						state <= CCS_DONE;
					end
				end
				CCS_SUSPEND: if (ts_start_ok) state <= CCS_CHARGE;
				CCS_TFAULT: if (restart) state <= CCS_IDLE;
				default: state <= CCS_IDLE;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce_prev <= 1'b1;
			ce_toggled <= 1'b0;
		end else begin
			ce_prev <= chg_enable_n;
			ce_toggled <= chg_enable_n && !ce_prev;
		end
	end
	assign restart = new_cycle || ce_toggled || (wr_done && idx == REG_CHG_CFG &&
		chg_cfg == 2'h0 && pwdata[CFG_LSB+:2] == CFG_CHARGE) || (wr_done && idx == REG_TERM &&
		!timer_en && pwdata[TMR_EN_BIT]);
	// ----------------------------------------------------------------
	// Charge timers
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt;
	logic sec_tick, half_rate;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= '0;
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
		end
	end
	always_comb begin
		// Default mode uses the fixed 5 h limit.
		safe_limit = TIMER_W'(DEF_HRS * HOUR_S);
		if (host_mode) begin
			unique case (timer_dur)
				2'h0: safe_limit = TIMER_W'(SAFE_HRS0 * HOUR_S);
				2'h1: safe_limit = TIMER_W'(SAFE_HRS1 * HOUR_S);
				2'h2: safe_limit = TIMER_W'(SAFE_HRS2 * HOUR_S);
				default: safe_limit = TIMER_W'(SAFE_HRS3 * HOUR_S);
			endcase
		end
		// Low battery caps at one hour.
		if (batt.vbat_below_low) begin
			safe_limit = TIMER_W'(LOWBAT_HRS * HOUR_S);
		end
	end
	// Half rate during regulation or reduced current.
	assign half_rate = half_en && (any_reg || reduced_current_bit);
	ccs_timer #(.W(TIMER_W)) u_safe (
		.pclk(pclk),
		.presetn(presetn),
		.clear(restart),
		.run(timer_en && state == CCS_CHARGE),
		.tick(sec_tick),
		.half(half_rate),
		.limit(safe_limit),
		.expired(safe_exp)
	);
	ccs_timer #(.W(TIMER_W)) u_usb (
		.pclk(pclk),
		.presetn(presetn),
		.clear(restart),
		.run(!host_mode && src.usb100 && state == CCS_CHARGE),
		.tick(sec_tick),
		.half(1'b0),
		.limit(TIMER_W'(USB_MIN * MIN_S)),
		.expired(usb_exp)
	);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_high_impedance_bit <= 1'b0;
		end else if ((safe_exp && !host_mode) || usb_exp) begin
			// Expiry stops the buck; USB expiry too.
			input_high_impedance_bit <= 1'b1;
		end else if (safe_exp) begin
			// Host-mode expiry keeps the converter running.
			input_high_impedance_bit <= 1'b0;
		end else if (wr_done && idx == REG_HIZ) begin
			input_high_impedance_bit <= pwdata[HIZ_BIT];
		end
	end
	// ----------------------------------------------------------------
	// Status, faults and pins
	// ----------------------------------------------------------------
	logic [2:0] ts_now;
	logic [7:0] fault_now;
	logic ts_evt, done_evt, tmr_evt, fault_evt, alert_req;
	assign ts_now = (state == CCS_SUSPEND) ? {|(ts_hot_cut | ts_hot_start), !in_run[1] ||
		!in_start[1], !in_run[0] || !in_start[0]} : 3'h0;
	assign fault_now = {2'h0, chg_fault, 1'b0, ts_now};
	assign ts_evt = (state == CCS_CHARGE) && chg_req && !ts_run_ok;
	assign tmr_evt = (state == CCS_CHARGE) && chg_req && (safe_exp || usb_exp);
	assign done_evt = (state == CCS_CHARGE) && chg_req && ts_run_ok && term_ok && !safe_exp &&
		!usb_exp;
	// No fault alert before the fault read.
	assign fault_evt = (ts_evt || tmr_evt) && !fault_pending;
	assign alert_req = fault_evt || done_evt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_fault <= 2'h0;
		end else if (tmr_evt) begin
			chg_fault <= CF_TIMER;
		end else if (restart) begin
			chg_fault <= 2'h0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_reg <= 8'h00;
			fault_pending <= 1'b0;
		end else if (rd_fault) begin
			fault_reg <= fault_now;
			fault_pending <= fault_evt;
		end else begin
			fault_reg <= fault_reg | fault_now;
			fault_pending <= fault_pending || fault_evt;
		end
	end
	logic [31:0] alert_cnt;
	logic alert_queued;
	// One fixed-width low pulse per event.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alert_n <= 1'b1;
			alert_cnt <= '0;
			alert_queued <= 1'b0;
		end else if (!alert_n) begin
			alert_queued <= alert_queued || alert_req;
			alert_cnt <= alert_cnt + 1'b1;
			if (alert_cnt == 32'(ALERT_CYCLES - 1)) begin
				alert_n <= 1'b1;
			end
		end else if ((alert_req || alert_queued) && alert_cnt == '0) begin
			alert_n <= 1'b0;
			alert_queued <= 1'b0;
		end else begin
			alert_queued <= alert_queued || alert_req;
			alert_cnt <= '0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_stat <= ST_IDLE;
			charge_on <= 1'b0;
			battery_switch_on <= 1'b1;
			buck_enable <= 1'b0;
			charge_done_ind <= 1'b0;
			power_good_pin_n <= 1'b1;
		end else begin
			chg_stat <= (state == CCS_DONE) ? ST_DONE : (state == CCS_CHARGE) ? ST_FAST :
				ST_IDLE;
			charge_on <= (state == CCS_CHARGE);
			battery_switch_on <= (state != CCS_DONE);
			buck_enable <= pg_now && !input_high_impedance_bit;
			charge_done_ind <= (state == CCS_DONE) || (state == CCS_CHARGE && early_done &&
				ichg_ma < EARLY_DONE_MA);
			power_good_pin_n <= !pg_now;
		end
	end
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	vreg_bound_a: assert property ($past(presetn) |-> vreg_mv >= $past(base_mv) &&
		vreg_mv - $past(base_mv) <= $past(clamp_mv))
		else $error("regulation target outside compensation range");
	start_window_a: assert property ((state == CCS_IDLE ##1 state == CCS_CHARGE) |->
		$past(ts_start_ok))
		else $error("charge started outside start window");
	ts_suspend_a: assert property (ts_evt |=> state == CCS_SUSPEND ##1 chg_stat == ST_IDLE)
		else $error("no suspend on thermistor exit");
	done_stat_a: assert property (done_evt |=> ##1 chg_stat == ST_DONE && !battery_switch_on)
		else $error("termination not reported");
	term_block_a: assert property ((state == CCS_CHARGE && (any_reg || !term_en)) |=>
		state != CCS_DONE)
		else $error("termination during regulation or disabled");
	timer_fault_a: assert property (tmr_evt |=> chg_fault == CF_TIMER ##1
		fault_reg[5:4] == CF_TIMER || rd_fault)
		else $error("timer fault not loaded");
	hiz_set_a: assert property ((safe_exp && !host_mode) |=> input_high_impedance_bit)
		else $error("default expiry left converter on");
	pg_pin_a: assert property (##1 power_good_pin_n == !$past(pg_now))
		else $error("power good pin wrong");
	alert_width_a: assert property ($rose(alert_n) |-> $past(alert_cnt) ==
		32'(ALERT_CYCLES - 1))
		else $error("alert pulse width wrong");
	alert_hold_a: assert property ((fault_pending && !rd_fault) |=> fault_pending)
		else $error("fault alert released without read");
	done_c: cover property (state == CCS_CHARGE ##1 state == CCS_DONE);
	suspend_c: cover property (state == CCS_SUSPEND ##1 state == CCS_CHARGE);
	tfault_c: cover property (state == CCS_TFAULT);
	alert_c: cover property ($rose(alert_n));
endmodule : ccs_supervisor
`default_nettype wire

/* File: ccs_host_model.sv */
// Host processor model: APB master for the supervisor registers.
`timescale 1ns/1ps
`default_nettype none
module ccs_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic [31:0] r0;
	logic e0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// ----------------------------------------------------------------
	// Bus transfers
	// ----------------------------------------------------------------
	// The request is held until pready, then released with data inverted.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
	task automatic set_term(input logic [31:0] d);
		xfer(1'b1, 12'h014, d & ~32'h8, r0, e0);
		xfer(1'b1, 12'h014, d, r0, e0);
	endtask : set_term
endmodule : ccs_host_model
`default_nettype wire

/* File: charge_cycle_supervisor_tb_top.sv */
// Self-checking testbench of the charge cycle supervisor.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_supervisor_tb_top import ccs_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chg_enable_n, err;
	logic [11:0] paddr, ichg_ma;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] ts_cold, ts_hot_start, ts_hot_cut;
	logic [15:0] vreg_mv;
	logic charge_on, battery_switch_on, buck_enable, charge_done_ind, power_good_pin_n, alert_n;
	ccs_batt_t batt;
	ccs_src_t src;
	int miscompares, cmp_count, n;
	ccs_supervisor #(.TICK_CYCLES(4), .ALERT_CYCLES(8)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .chg_enable_n, .batt, .src,
		.ichg_ma, .ts_cold, .ts_hot_start, .ts_hot_cut, .vreg_mv, .charge_on,
		.battery_switch_on, .buck_enable, .charge_done_ind, .power_good_pin_n, .alert_n);
	ccs_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check
	task automatic rdc(input logic [3:0] i, input logic [31:0] m, input logic [31:0] e);
		u_host.xfer(1'b0, {6'h00, i, 2'b00}, 32'h0, rd, err);
		check(rd & m, e);
	endtask : rdc
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc
	// Waits for an alert pulse and measures its length in cycles.
	task automatic alert_len(input int lim);
		n = 0;
		while (alert_n !== 1'b0 && n < lim) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		while (alert_n === 1'b0 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		check(n, 32'h8);
	endtask : alert_len
	task automatic results;
		$display("mismatches=%0d comparisons=%0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		repeat (40000) @(posedge pclk);
		miscompares++;
		results();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		chg_enable_n = 1'b1;
		batt = '0;
		src = '0;
		ichg_ma = 12'h000;
		ts_cold = 2'h0;
		ts_hot_start = 2'h0;
		ts_hot_cut = 2'h0;
		miscompares = 0;
		cmp_count = 0;
		cyc(20);
		presetn <= 1'b1;
		rdc(REG_CHG_CFG, 32'hff, 32'h10);
		rdc(REG_TERM, 32'hff, 32'h8a);
		rdc(REG_MISC, 32'hff, 32'h40);
		u_host.xfer(1'b0, 12'h00c, 32'h0, rd, err);
		check({rd[30:0], err}, 32'h1);
		for (int b = 1; b < 5; b++) begin
			src <= 5'b11110 ^ (5'b00001 << b);
			cyc(3);
			check(power_good_pin_n, 32'h1);
		end
		src <= 5'b11110;
		cyc(3);
		check(power_good_pin_n, 32'h0);
		ts_hot_start <= 2'b10;
		chg_enable_n <= 1'b0;
		cyc(5);
		check(charge_on, 32'h0);
		ts_hot_start <= 2'b00;
		cyc(5);
		check(charge_on, 32'h1);
		u_host.xfer(1'b1, 12'h018, 32'h7c, rd, err);
		ichg_ma <= 12'h3e8;
		cyc(4);
		check(vreg_mv, 32'h0f3a);
		ichg_ma <= 12'hfa0;
		cyc(4);
		check(vreg_mv, 32'h0f8c);
		ts_hot_start <= 2'b10;
		ts_hot_cut <= 2'b10;
		alert_len(20);
		check(charge_on, 32'h0);
		rdc(REG_FAULT, 32'h7, 32'h6);
		ts_hot_cut <= 2'b00;
		cyc(5);
		check(charge_on, 32'h0);
		ts_hot_start <= 2'b00;
		cyc(5);
		check(charge_on, 32'h1);
		rdc(REG_FAULT, 32'h7, 32'h6);
		rdc(REG_FAULT, 32'h7, 32'h0);
		ts_cold <= 2'b01;
		cyc(5);
		check(charge_on, 32'h0);
		ts_cold <= 2'b00;
		cyc(5);
		rdc(REG_FAULT, 32'h7, 32'h1);
		rdc(REG_FAULT, 32'h7, 32'h0);
		batt <= 6'b101100;
		cyc(10);
		check(charge_done_ind, 32'h0);
		u_host.set_term(32'h0a);
		batt <= 6'b101000;
		cyc(10);
		check(charge_done_ind, 32'h0);
		u_host.set_term(32'h4a);
		check(charge_done_ind, 32'h0);
		ichg_ma <= 12'h2bc;
		cyc(3);
		check(charge_done_ind, 32'h1);
		check(charge_on, 32'h1);
		// Regulation holds termination off until the enable writes are done.
		batt <= 6'b101100;
		u_host.set_term(32'h8a);
		batt <= 6'b101000;
		alert_len(20);
		check(battery_switch_on, 32'h0);
		rdc(REG_STAT, 32'h30, 32'h30);
		// Host ends charging through the enable pin, then restarts.
		chg_enable_n <= 1'b1;
		batt <= 6'b010000;
		cyc(3);
		chg_enable_n <= 1'b0;
		alert_len(15000);
		rdc(REG_FAULT, 32'h30, 32'h30);
		rdc(REG_HIZ, 32'h80, 32'h80);
		check(buck_enable, 32'h0);
		// Clearing the high-impedance bit restarts charging; host mode then keeps it clear.
		u_host.xfer(1'b1, 12'h000, 32'h0, rd, err);
		u_host.xfer(1'b1, 12'h028, 32'h1, rd, err);
		check(buck_enable, 32'h1);
		check(charge_on, 32'h1);
		alert_len(15000);
		check(charge_on, 32'h0);
		check(buck_enable, 32'h1);
		rdc(REG_HIZ, 32'h80, 32'h0);
		results();
	end
endmodule : charge_cycle_supervisor_tb_top
`default_nettype wire
